// *** core/timer01_core.sv ***
// Timer 0 and Timer 1 with clock selection and an APB register slave.
module timer01_core
  import timer01_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        timer0_event_pin,
  input  wire logic        timer1_event_pin,
  input  wire logic        ext_gate_input_a,
  input  wire logic        ext_gate_input_b,
  input  wire logic        ext_osc_clk,
  input  wire logic        timer0_vector_ack,
  input  wire logic        timer1_vector_ack,
  input  wire logic        timer2_alt_tick,
  input  wire logic        timer3_alt_tick,
  output logic             timer0_irq,
  output logic             timer1_irq,
  output logic             timer1_overflow,
  output logic             timer2_lo_tick,
  output logic             timer2_hi_tick,
  output logic             timer3_lo_tick,
  output logic             timer3_hi_tick
);

  // --------------------------------------------------------------------
  // Declarations
  // --------------------------------------------------------------------
  localparam int PIN_N = 5;
  localparam int PIN_EV0 = 0;
  localparam int PIN_EV1 = 1;
  localparam int PIN_GA = 2;
  localparam int PIN_GB = 3;
  localparam int PIN_OSC = 4;

  logic [7:0]       clock_sel_r;
  logic [7:0]       ext_cfg_r;
  timer_cfg_type    cfg0_r;
  timer_cfg_type    cfg1_r;
  logic             run0_r;
  logic             run1_r;
  logic [CT_EXT_W-1:0] ext_ctl_r;
  logic             flag0_r;
  logic             flag1_r;
  logic [7:0]       t0_lo_r;
  logic [7:0]       t0_hi_r;
  logic [7:0]       t1_lo_r;
  logic [7:0]       t1_hi_r;
  logic [PIN_N-1:0] pin_meta_r;
  logic [PIN_N-1:0] pin_sync_r;
  logic [PIN_N-1:0] pin_prev_r;
  logic [3:0]       div12_r;
  logic [1:0]       quad_r;
  logic [2:0]       ext_div_r;
  logic [IDX_W-1:0] idx;
  logic             mapped;
  logic             wr_en;
  logic [7:0]       rd_byte;
  logic             tick4;
  logic             tick12;
  logic             tick48;
  logic             ext_edge;
  logic             ext_tick;
  logic             presc_tick;
  logic             tclk0;
  logic             tclk1;
  logic             fall0;
  logic             fall1;
  logic             gate_ok_a;
  logic             gate_ok_b;
  logic             split0;
  logic             tick0;
  logic             tick1;
  logic             adv0;
  logic             adv1;
  logic             hi_adv;
  logic             flag0_set;
  logic             flag1_set;
  logic             flag0_clr;
  logic             flag1_clr;
  count_step_type   step0;
  count_step_type   step1;

  // --------------------------------------------------------------------
  // Helper functions
  // --------------------------------------------------------------------
  // Next count and overflow for one timer in the given mode.
  function automatic count_step_type step_count(
    input logic [7:0]     hi,
    input logic [7:0]     lo,
    input timer_mode_type mode
  );
    count_step_type r;
    logic [12:0]    c13;
    r   = '0;
    c13 = {hi, lo[LO5_W-1:0]} + 13'h0001;
    case (mode)
      MODE_13BIT: begin
        r.val = {c13[12:LO5_W], lo[7:LO5_W], c13[LO5_W-1:0]};
        r.ovf = &{hi, lo[LO5_W-1:0]};
      end
      MODE_16BIT: begin
        r.val = {hi, lo} + 16'h0001;
        r.ovf = &{hi, lo};
      end
      MODE_RELOAD8: begin
        r.val = {hi, (&lo) ? hi : lo + 8'h01};
        r.ovf = &lo;
      end
      default: begin
        r.val = {hi, lo + 8'h01};
        r.ovf = &lo;
      end
    endcase
    return r;
  endfunction : step_count

  // Register read mux for one index.
  function automatic logic [7:0] read_byte(input logic [IDX_W-1:0] i);
    logic [7:0] v;
    v = RESET_BYTE;
    case (i)
      IDX_CONTROL:   v = {flag1_r, run1_r, flag0_r, run0_r, ext_ctl_r};
      IDX_MODE:      v = {cfg1_r, cfg0_r};
      IDX_T0_LO:     v = t0_lo_r;
      IDX_T1_LO:     v = t1_lo_r;
      IDX_T0_HI:     v = t0_hi_r;
      IDX_T1_HI:     v = t1_hi_r;
      IDX_CLOCK_SEL: v = clock_sel_r;
      IDX_EXT_CFG:   v = ext_cfg_r;
      default:       v = RESET_BYTE;
    endcase
    return v;
  endfunction : read_byte

  // --------------------------------------------------------------------
  // APB slave
  // --------------------------------------------------------------------
  // Decode the word index; upper and lane bits must be zero.
  assign idx    = paddr[ADDR_LSB +: IDX_W];
  assign mapped = (paddr[11:ADDR_LSB+IDX_W] == '0)
                  && (paddr[ADDR_LSB-1:0] == '0)
                  && (idx inside {IDX_CONTROL, IDX_MODE, IDX_T0_LO,
                                  IDX_T1_LO, IDX_T0_HI, IDX_T1_HI,
                                  IDX_CLOCK_SEL, IDX_EXT_CFG});
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign wr_en   = psel && penable && pwrite && mapped;

  // A process rather than an assign, so register changes re-run the mux.
  always_comb begin
    rd_byte = read_byte(idx);
  end

  // Read data is captured in the setup cycle, ready in the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (psel && !penable && !pwrite) begin
      prdata <= {24'h000000, mapped ? rd_byte : RESET_BYTE};
    end
  end

  // Configuration registers written by software.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_sel_r <= RESET_BYTE;
      ext_cfg_r   <= RESET_BYTE;
      cfg0_r      <= '0;
      cfg1_r      <= '0;
      run0_r      <= 1'b0;
      run1_r      <= 1'b0;
      ext_ctl_r   <= '0;
    end else if (wr_en) begin
      case (idx)
        IDX_CLOCK_SEL: clock_sel_r <= pwdata[7:0];
        IDX_EXT_CFG:   ext_cfg_r   <= pwdata[7:0];
        IDX_MODE:      {cfg1_r, cfg0_r} <= pwdata[7:0];
        IDX_CONTROL: begin
          run1_r    <= pwdata[CT_T1_RUN];
          run0_r    <= pwdata[CT_T0_RUN];
          ext_ctl_r <= pwdata[CT_EXT_W-1:0];
        end
        default: ;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Pin synchronisers and edge detect
  // --------------------------------------------------------------------
  // Two stages per pin, then a third stage for edges.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
      pin_prev_r <= '0;
    end else begin
      pin_meta_r <= {ext_osc_clk, ext_gate_input_b, ext_gate_input_a,
                     timer1_event_pin, timer0_event_pin};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // Falling edges on the synchronised event pins, a rising edge on the oscillator.
  assign fall0    = pin_prev_r[PIN_EV0] && !pin_sync_r[PIN_EV0];
  assign fall1    = pin_prev_r[PIN_EV1] && !pin_sync_r[PIN_EV1];
  assign ext_edge = !pin_prev_r[PIN_OSC] && pin_sync_r[PIN_OSC];

  // Gate levels compared with the configured active polarity.
  assign gate_ok_a = !cfg0_r.pin_gating
                     || (pin_sync_r[PIN_GA] == ext_cfg_r[CFG_POL_A]);
  assign gate_ok_b = !cfg1_r.pin_gating
                     || (pin_sync_r[PIN_GB] == ext_cfg_r[CFG_POL_B]);

  // --------------------------------------------------------------------
  // Prescaler
  // --------------------------------------------------------------------
  // Divide by 12, its low bits giving /4 and a quarter counter giving /48.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div12_r <= '0;
      quad_r  <= '0;
    end else begin
      div12_r <= (div12_r == DIV12_LAST) ? '0 : div12_r + 4'h1;
      if (tick12) begin
        quad_r <= quad_r + 2'h1;
      end
    end
  end

  // External clock edges counted by eight.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_div_r <= '0;
    end else if (ext_edge) begin
      ext_div_r <= ext_div_r + 3'h1;
    end
  end

  assign tick12   = (div12_r == DIV12_LAST);
  assign tick4    = (div12_r[1:0] == DIV4_LAST);
  assign tick48   = tick12 && (quad_r == QUAD_LAST);
  assign ext_tick = ext_edge && (ext_div_r == EXT_DIV_LAST);

  // Prescaled tick chosen by the shared divider field.
  always_comb begin
    case (divider_type'(clock_sel_r[CK_DIV +: 2]))
      DIV_BY_12: presc_tick = tick12;
      DIV_BY_4:  presc_tick = tick4;
      DIV_BY_48: presc_tick = tick48;
      DIV_EXT_8: presc_tick = ext_tick;
      default:   presc_tick = 1'b0;
    endcase
  end

  // Timer clocks: system clock or prescaled tick.
  assign tclk0 = clock_sel_r[CK_T0_SYS] | presc_tick;
  assign tclk1 = clock_sel_r[CK_T1_SYS] | presc_tick;

  // Clock choices handed to the Timer 2 and Timer 3 bytes.
  assign timer2_lo_tick = clock_sel_r[CK_T2_LO] | timer2_alt_tick;
  assign timer2_hi_tick = clock_sel_r[CK_T2_HI] | timer2_alt_tick;
  assign timer3_lo_tick = clock_sel_r[CK_T3_LO] | timer3_alt_tick;
  assign timer3_hi_tick = clock_sel_r[CK_T3_HI] | timer3_alt_tick;

  // --------------------------------------------------------------------
  // Count enables
  // --------------------------------------------------------------------
  // Timer 0 (or its low byte in split mode) and the split high byte.
  assign split0 = (cfg0_r.mode_field == MODE_SPLIT);
  assign tick0  = cfg0_r.count_select ? fall0 : tclk0;
  assign adv0   = run0_r && gate_ok_a && tick0;
  assign hi_adv = split0 && run1_r && tclk0;
  assign step0  = step_count(t0_hi_r, t0_lo_r, cfg0_r.mode_field);

  // Timer 1 loses pin clocking and its run bit while Timer 0 is split.
  assign tick1 = (cfg1_r.count_select && !split0) ? fall1 : tclk1;
  assign adv1  = (cfg1_r.mode_field != MODE_SPLIT) && tick1
                 && (split0 || (run1_r && gate_ok_b));
  assign step1 = step_count(t1_hi_r, t1_lo_r, cfg1_r.mode_field);

  // --------------------------------------------------------------------
  // Count registers
  // --------------------------------------------------------------------
  // Timer 0 bytes; a software write wins over counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t0_lo_r <= RESET_BYTE;
      t0_hi_r <= RESET_BYTE;
    end else begin
      if (wr_en && idx == IDX_T0_LO) begin
        t0_lo_r <= pwdata[7:0];
      end else if (adv0) begin
        t0_lo_r <= step0.val[7:0];
      end
      if (wr_en && idx == IDX_T0_HI) begin
        t0_hi_r <= pwdata[7:0];
      end else if (hi_adv) begin
        t0_hi_r <= t0_hi_r + 8'h01;
      end else if (adv0 && !split0) begin
        t0_hi_r <= step0.val[15:8];
      end
    end
  end

  // Timer 1 bytes; a software write wins over counting.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_lo_r <= RESET_BYTE;
      t1_hi_r <= RESET_BYTE;
    end else begin
      if (wr_en && idx == IDX_T1_LO) begin
        t1_lo_r <= pwdata[7:0];
      end else if (adv1) begin
        t1_lo_r <= step1.val[7:0];
      end
      if (wr_en && idx == IDX_T1_HI) begin
        t1_hi_r <= pwdata[7:0];
      end else if (adv1) begin
        t1_hi_r <= step1.val[15:8];
      end
    end
  end

  // --------------------------------------------------------------------
  // Overflow flags
  // --------------------------------------------------------------------
  assign flag0_set = adv0 && step0.ovf;
  assign flag1_set = split0 ? (hi_adv && (&t0_hi_r))
                            : (adv1 && step1.ovf);
  assign flag0_clr = timer0_vector_ack
                     || (wr_en && idx == IDX_CONTROL
                         && !pwdata[CT_T0_FLG]);
  assign flag1_clr = timer1_vector_ack
                     || (wr_en && idx == IDX_CONTROL
                         && !pwdata[CT_T1_FLG]);

  // Software may also set a flag; a hardware set wins over any clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag0_r <= 1'b0;
      flag1_r <= 1'b0;
    end else begin
      if (flag0_set || (wr_en && idx == IDX_CONTROL
                        && pwdata[CT_T0_FLG])) begin
        flag0_r <= 1'b1;
      end else if (flag0_clr) begin
        flag0_r <= 1'b0;
      end
      if (flag1_set || (wr_en && idx == IDX_CONTROL
                        && pwdata[CT_T1_FLG])) begin
        flag1_r <= 1'b1;
      end else if (flag1_clr) begin
        flag1_r <= 1'b0;
      end
    end
  end

  // Timer 1 overflow pulse kept even in split mode for baud use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer1_overflow <= 1'b0;
    end else begin
      timer1_overflow <= adv1 && step1.ovf;
    end
  end

  assign timer0_irq = flag0_r && ext_cfg_r[CFG_IRQ0];
  assign timer1_irq = flag1_r && ext_cfg_r[CFG_IRQ1];

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic wr_t0;
  assign wr_t0 = wr_en && (idx == IDX_T0_LO || idx == IDX_T0_HI);

  chk_mode0_wrap_flag: assert property (
    (adv0 && cfg0_r.mode_field == MODE_13BIT && !wr_t0
     && (&{t0_hi_r, t0_lo_r[4:0]}))
    |=> (flag0_r && t0_hi_r == 8'h00 && t0_lo_r[4:0] == 5'h00))
    else $error("mode 0 wrap did not clear count and set flag");

  chk_reload_low_byte: assert property (
    (adv0 && cfg0_r.mode_field == MODE_RELOAD8 && !wr_t0
     && t0_lo_r == 8'hff)
    |=> (t0_lo_r == $past(t0_hi_r) && $stable(t0_hi_r) && flag0_r))
    else $error("mode 2 reload failed");

  chk_prescale_period: assert property (
    tick12 |-> ##12 tick12)
    else $error("divide by 12 tick period wrong");

  chk_prescale_48: assert property (
    tick48 |=> !tick48 [*8] ##40 tick48)
    else $error("divide by 48 tick period wrong");

  chk_gate_hold: assert property (
    (!(run0_r && gate_ok_a) && !wr_t0 && !split0) |=> $stable(t0_lo_r))
    else $error("timer 0 moved while not running");

  chk_pin_edge_count: assert property (
    (cfg0_r.count_select && run0_r && gate_ok_a && !wr_t0
     && cfg0_r.mode_field == MODE_16BIT && $fell(pin_sync_r[PIN_EV0]))
    |=> (t0_lo_r == $past(t0_lo_r) + 8'h01))
    else $error("falling pin edge not counted");

  chk_split_hi_flag: assert property (
    (split0 && run1_r && clock_sel_r[CK_T0_SYS] && t0_hi_r == 8'hff
     && !wr_t0)
    |=> (flag1_r && t0_hi_r == 8'h00))
    else $error("split high byte overflow missed");

  chk_t1_mode3_stop: assert property (
    (cfg1_r.mode_field == MODE_SPLIT && !wr_en)
    |=> $stable({t1_hi_r, t1_lo_r}))
    else $error("timer 1 counted in mode 3");

  chk_flag_set_wins: assert property (
    (flag0_set && timer0_vector_ack) |=> flag0_r)
    else $error("flag clear beat the set");

  cov_split_low_ovf: cover property (split0 && flag0_set);
  cov_t1_overflow: cover property (timer1_overflow);
  cov_reload: cover property (
    cfg0_r.mode_field == MODE_RELOAD8 && flag0_set);

endmodule : timer01_core

// *** core/timer01_pkg.sv ***
// Shared constants and types for the Timer 0/1 block.
package timer01_pkg;

  // --------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // --------------------------------------------------------------------
  localparam int        ADDR_LSB       = 2;
  localparam int        IDX_W          = 8;
  localparam logic [7:0] IDX_CONTROL   = 8'h88;
  localparam logic [7:0] IDX_MODE      = 8'h89;
  localparam logic [7:0] IDX_T0_LO     = 8'h8a;
  localparam logic [7:0] IDX_T1_LO     = 8'h8b;
  localparam logic [7:0] IDX_T0_HI     = 8'h8c;
  localparam logic [7:0] IDX_T1_HI     = 8'h8d;
  localparam logic [7:0] IDX_CLOCK_SEL = 8'h8e;
  localparam logic [7:0] IDX_EXT_CFG   = 8'h90;
  localparam logic [7:0] RESET_BYTE    = 8'h00;

  // --------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------
  localparam int CK_T3_HI  = 7;
  localparam int CK_T3_LO  = 6;
  localparam int CK_T2_HI  = 5;
  localparam int CK_T2_LO  = 4;
  localparam int CK_T1_SYS = 3;
  localparam int CK_T0_SYS = 2;
  localparam int CK_DIV    = 0;
  localparam int CT_T1_FLG = 7;
  localparam int CT_T1_RUN = 6;
  localparam int CT_T0_FLG = 5;
  localparam int CT_T0_RUN = 4;
  localparam int CT_EXT_W  = 4;
  localparam int CFG_POL_A = 0;
  localparam int CFG_POL_B = 1;
  localparam int CFG_IRQ0  = 2;
  localparam int CFG_IRQ1  = 3;
  localparam int LO5_W     = 5;

  // --------------------------------------------------------------------
  // Prescaler terminal counts
  // --------------------------------------------------------------------
  localparam logic [3:0] DIV12_LAST   = 4'hb;
  localparam logic [1:0] DIV4_LAST    = 2'h3;
  localparam logic [1:0] QUAD_LAST    = 2'h3;
  localparam logic [2:0] EXT_DIV_LAST = 3'h7;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    DIV_BY_12 = 2'h0,
    DIV_BY_4  = 2'h1,
    DIV_BY_48 = 2'h2,
    DIV_EXT_8 = 2'h3
  } divider_type;

  typedef enum logic [1:0] {
    MODE_13BIT   = 2'h0,
    MODE_16BIT   = 2'h1,
    MODE_RELOAD8 = 2'h2,
    MODE_SPLIT   = 2'h3
  } timer_mode_type;

  typedef struct packed {
    logic           pin_gating;
    logic           count_select;
    timer_mode_type mode_field;
  } timer_cfg_type;

  typedef struct packed {
    logic [15:0] val;
    logic        ovf;
  } count_step_type;

endpackage : timer01_pkg

// *** tb/ext_pins_model.sv ***
// Model of the timer event pins, gate inputs and external oscillator.
module ext_pins_model (
  input  wire logic pclk,
  output logic      timer0_event_pin,
  output logic      timer1_event_pin,
  output logic      ext_gate_input_a,
  output logic      ext_gate_input_b,
  output logic      ext_osc_clk
);
  timeunit 1ns;
  timeprecision 100ps;

  // Pins idle high, gates start low, the oscillator runs free.
  initial begin
    timer0_event_pin = 1'b1;
    timer1_event_pin = 1'b1;
    ext_gate_input_a = 1'b0;
    ext_gate_input_b = 1'b0;
    ext_osc_clk      = 1'b0;
  end

  // The odd half period puts only every tenth oscillator edge on a clock edge.
  always #16.5 ext_osc_clk = ~ext_osc_clk;

  // Gives n low pulses on pin 0, pin 1, or both when sel is 2.
  task pulse(input int sel, input int n);
    for (int i = 0; i < 2 * n; i++) begin
      if (sel != 1) timer0_event_pin <= i[0];
      if (sel != 0) timer1_event_pin <= i[0];
      repeat (4) @(posedge pclk);
    end
  endtask : pulse

  // Sets both gate levels and lets one edge pass.
  task gates(input logic a, input logic b);
    ext_gate_input_a <= a;
    ext_gate_input_b <= b;
    @(posedge pclk);
  endtask : gates
endmodule : ext_pins_model

// *** tb/timer0_timer1_counter_clocking_bench.sv ***
// Self-checking bench for the Timer 0/1 block through its APB port.
module timer0_timer1_counter_clocking_bench import timer01_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, timer0_vector_ack = 1'b0;
  logic        timer1_vector_ack = 1'b0, timer2_alt_tick = 1'b0;
  logic        timer3_alt_tick = 1'b0, pready, pslverr, e;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata;
  logic        timer0_event_pin, timer1_event_pin, ext_osc_clk;
  logic        ext_gate_input_a, ext_gate_input_b;
  logic        timer0_irq, timer1_irq, timer1_overflow;
  logic        timer2_lo_tick, timer2_hi_tick, timer3_lo_tick;
  logic        timer3_hi_tick;
  logic [7:0]  v, v0, ticks;
  int          n_errors = 0, n_compared = 0, ovf_n = 0, snap;

  localparam logic [7:0] CK_SET [6] = '{8'h00, 8'h01, 8'h02, 8'h03,
                                        8'h04, 8'h08};
  localparam logic [7:0] MIN_CT [6] = '{8'd7, 8'd23, 8'd1, 8'd2,
                                        8'd95, 8'd95};
  localparam logic [7:0] MAX_CT [6] = '{8'd9, 8'd25, 8'd3, 8'd5,
                                        8'd97, 8'd97};

  // Clock tick outputs gathered as {t3 hi, t3 lo, t2 hi, t2 lo}.
  assign ticks = {4'h0, timer3_hi_tick, timer3_lo_tick, timer2_hi_tick,
                  timer2_lo_tick};

  timer01_core dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .timer0_event_pin, .timer1_event_pin,
    .ext_gate_input_a, .ext_gate_input_b, .ext_osc_clk,
    .timer0_vector_ack, .timer1_vector_ack, .timer2_alt_tick,
    .timer3_alt_tick, .timer0_irq, .timer1_irq, .timer1_overflow,
    .timer2_lo_tick, .timer2_hi_tick, .timer3_lo_tick, .timer3_hi_tick
  );

  ext_pins_model pins (
    .pclk, .timer0_event_pin, .timer1_event_pin, .ext_gate_input_a,
    .ext_gate_input_b, .ext_osc_clk
  );

  // The clock runs at 100 MHz.
  always #5 pclk = ~pclk;

  // Counts the Timer 1 overflow pulses.
  always @(posedge pclk) begin
    if (timer1_overflow === 1'b1) ovf_n <= ovf_n + 1;
  end

  // Compares a value against an inclusive range.
  task check(input logic [7:0] got, input logic [7:0] lo, hi);
    n_compared++;
    if ((^got === 1'bx) || got < lo || got > hi) begin
      n_errors++;
      $display("wrong value at %0t: got %h, want %h..%h", $time, got, lo,
               hi);
    end
  endtask : check

  // One APB transfer, entered just after a rising edge.
  task xfer(input logic [7:0] idx, input logic wr, input logic [7:0] wd,
            output logic [7:0] rd, output logic err);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer

  // Writes one register byte.
  task wr(input logic [7:0] idx, input logic [7:0] d);
    xfer(idx, 1'b1, d, v, e);
  endtask : wr

  // Reads one register byte and compares it.
  task rd(input logic [7:0] idx, input logic [7:0] exp);
    xfer(idx, 1'b0, 8'h00, v, e);
    check(v, exp, exp);
  endtask : rd

  // Prints the counts and the verdict, then ends the run.
  task close_out;
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : close_out

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    close_out();
  end

  // Main sequence: reset, clock selection, then each timer mode.
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(IDX_CLOCK_SEL, RESET_BYTE);
    xfer(8'h8f, 1'b0, 8'h00, v, e);
    check({7'h0, e}, 8'h01, 8'h01);
    wr(IDX_CLOCK_SEL, 8'h50);
    check(ticks, 8'h05, 8'h05);
    timer2_alt_tick <= 1'b1;
    timer3_alt_tick <= 1'b1;
    @(posedge pclk);
    check(ticks, 8'h0f, 8'h0f);
    timer2_alt_tick <= 1'b0;
    timer3_alt_tick <= 1'b0;
    wr(IDX_CLOCK_SEL, 8'ha0);
    check(ticks, 8'h0a, 8'h0a);
    rd(IDX_CLOCK_SEL, 8'ha0);
    wr(IDX_MODE, 8'h11);
    wr(IDX_CONTROL, 8'h50);
    for (int i = 0; i < 6; i++) begin
      wr(IDX_CLOCK_SEL, CK_SET[i]);
      xfer(i == 5 ? IDX_T1_LO : IDX_T0_LO, 1'b0, 8'h00, v0, e);
      repeat (93) @(posedge pclk);
      xfer(i == 5 ? IDX_T1_LO : IDX_T0_LO, 1'b0, 8'h00, v, e);
      check(v - v0, MIN_CT[i], MAX_CT[i]);
    end
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CLOCK_SEL, 8'h00);
    wr(IDX_EXT_CFG, 8'h0c);
    wr(IDX_MODE, 8'h05);
    wr(IDX_T0_LO, 8'hfd);
    wr(IDX_T0_HI, 8'hff);
    wr(IDX_CONTROL, 8'h10);
    rd(IDX_T0_LO, 8'hfd);
    pins.pulse(0, 4);
    rd(IDX_T0_LO, 8'h01);
    rd(IDX_T0_HI, 8'h00);
    rd(IDX_CONTROL, 8'h30);
    check({7'h0, timer0_irq}, 8'h01, 8'h01);
    timer0_vector_ack <= 1'b1;
    @(posedge pclk);
    timer0_vector_ack <= 1'b0;
    rd(IDX_CONTROL, 8'h10);
    wr(IDX_MODE, 8'h04);
    wr(IDX_T0_LO, 8'h1f);
    wr(IDX_T0_HI, 8'hff);
    pins.pulse(0, 2);
    rd(IDX_T0_HI, 8'h00);
    xfer(IDX_T0_LO, 1'b0, 8'h00, v, e);
    check(v & 8'h1f, 8'h01, 8'h01);
    rd(IDX_CONTROL, 8'h30);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_MODE, 8'h60);
    wr(IDX_T1_HI, 8'h80);
    wr(IDX_T1_LO, 8'hfe);
    snap = ovf_n;
    wr(IDX_CONTROL, 8'h40);
    pins.pulse(1, 3);
    rd(IDX_T1_LO, 8'h81);
    rd(IDX_T1_HI, 8'h80);
    rd(IDX_CONTROL, 8'hc0);
    check(8'(ovf_n - snap), 8'h01, 8'h01);
    check({7'h0, timer1_irq}, 8'h01, 8'h01);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_EXT_CFG, 8'h02);
    wr(IDX_MODE, 8'hd0);
    wr(IDX_T1_LO, 8'h00);
    wr(IDX_CONTROL, 8'h40);
    pins.pulse(1, 2);
    rd(IDX_T1_LO, 8'h00);
    pins.gates(1'b0, 1'b1);
    pins.pulse(1, 2);
    rd(IDX_T1_LO, 8'h02);
    wr(IDX_EXT_CFG, 8'h00);
    pins.pulse(1, 2);
    rd(IDX_T1_LO, 8'h02);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_CLOCK_SEL, 8'h0c);
    wr(IDX_MODE, 8'h02);
    wr(IDX_T0_HI, 8'hff);
    wr(IDX_T0_LO, 8'hff);
    wr(IDX_CONTROL, 8'h10);
    timer0_vector_ack <= 1'b1;
    @(posedge pclk);
    timer0_vector_ack <= 1'b0;
    rd(IDX_CONTROL, 8'h30);
    rd(IDX_T0_LO, 8'hff);
    wr(IDX_CONTROL, 8'h00);
    wr(IDX_T0_LO, 8'hfe);
    wr(IDX_T0_HI, 8'hf0);
    wr(IDX_T1_LO, 8'hff);
    wr(IDX_T1_HI, 8'hff);
    snap = ovf_n;
    wr(IDX_MODE, 8'h17);
    wr(IDX_CONTROL, 8'h10);
    pins.pulse(2, 3);
    rd(IDX_T0_LO, 8'h01);
    rd(IDX_T0_HI, 8'hf0);
    rd(IDX_CONTROL, 8'h30);
    check(8'(ovf_n - snap), 8'h01, 8'h01);
    wr(IDX_MODE, 8'h37);
    xfer(IDX_T1_LO, 1'b0, 8'h00, v, e);
    rd(IDX_T1_LO, v);
    wr(IDX_CONTROL, 8'h50);
    repeat (20) @(posedge pclk);
    rd(IDX_CONTROL, 8'hd0);
    close_out();
  end
endmodule : timer0_timer1_counter_clocking_bench
